//--- logic/serial_channel_map.vh
// register map, field positions and reset values of the serial channel
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH
`define SEL_DATA 2'h0
`define SEL_STATUS 2'h1
`define SEL_FORMAT 2'h2
`define SEL_MASK 2'h3
`define BAUD_COUNT_ADDR 16'hFFE9
`define BAUD_COUNT_RESET 8'h00
`define FORMAT_RESET 8'h4B
`define COMMAND_RESET 8'h00
`define MASK_RESET 8'h03
`define CMD_TX_EN 0
`define CMD_DTR 1
`define CMD_RX_EN 2
`define CMD_BREAK 3
`define CMD_ERR_CLR 4
`define CMD_RTS 5
`define FMT_STOP_HI 7
`define FMT_STOP_LO 6
`define FMT_PAR_HI 5
`define FMT_PAR_LO 4
`define FMT_LEN_HI 3
`define FMT_LEN_LO 2
`define FMT_BF_HI 1
`define FMT_BF_LO 0
`define MASK_TX 1
`define MASK_RX 0
`define FACTOR_16_LAST 6'h0F
`define FACTOR_64_LAST 6'h3F
`define HALF_16_LAST 6'h07
`define HALF_64_LAST 6'h1F
`endif

//--- logic/tx_hold_buffer.v
// two-entry holding buffer between the transmit buffer register and the shifter
`timescale 1ns/1ns
module tx_hold_buffer (
    input wire clk,
    input wire rst_n,
    input wire en,
    input wire in_valid,
    input wire [7:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [7:0] out_data,
    input wire out_ready
);
    reg [7:0] mem_q [0:1];
    reg [1:0] count_q;
    reg wr_q;
    reg rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_q];

    always @(posedge clk) begin
        if (!rst_n) begin
            count_q <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else if (en) begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            if (push && !pop)
                count_q <= count_q + 2'h1;
            else if (pop && !push)
                count_q <= count_q - 2'h1;
        end
    end
endmodule // tx_hold_buffer

//--- logic/tx_shifter.v
// transmit shifter: start, data lsb first, optional parity, one or two stops
`timescale 1ns/1ns
`include "serial_channel_map.vh"
module tx_shifter (
    input wire clk,
    input wire rst_n,
    input wire en,
    input wire os_tick,
    input wire factor_64,
    input wire char8,
    input wire par_en,
    input wire par_even,
    input wire two_stop,
    input wire tx_enable,
    input wire valid,
    input wire [7:0] data,
    output wire ready,
    output reg txd
);
    localparam S_IDLE = 5'b00001;
    localparam S_START = 5'b00010;
    localparam S_DATA = 5'b00100;
    localparam S_PAR = 5'b01000;
    localparam S_STOP = 5'b10000;
    reg [4:0] st_q;
    reg [7:0] sh_q;
    reg [5:0] cnt_q;
    reg [2:0] bit_q;
    reg par_q;
    reg stop_q;
    wire [5:0] last = factor_64 ? `FACTOR_64_LAST : `FACTOR_16_LAST;
    wire [2:0] last_bit = char8 ? 3'h7 : 3'h6;
    wire bit_end = os_tick && (cnt_q == last);
    wire [7:0] masked = char8 ? data : {1'b0, data[6:0]};

    assign ready = st_q[0] && tx_enable;

    always @(posedge clk) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 6'h00;
            bit_q <= 3'h0;
            par_q <= 1'b0;
            stop_q <= 1'b0;
            txd <= 1'b1;
        end else if (en) begin
            if (os_tick)
                cnt_q <= bit_end ? 6'h00 : cnt_q + 6'h01;
            case (st_q)
                S_IDLE: begin
                    txd <= 1'b1;
                    if (valid && tx_enable) begin
                        sh_q <= masked;
                        par_q <= par_even ? ^masked : ~^masked;
                        st_q <= S_START;
                        cnt_q <= 6'h00;
                        txd <= 1'b0;
                    end
                end
                S_START: if (bit_end) begin
                    st_q <= S_DATA;
                    bit_q <= 3'h0;
                    txd <= sh_q[0];
                end
                S_DATA: if (bit_end) begin
                    if (bit_q == last_bit) begin
                        st_q <= par_en ? S_PAR : S_STOP;
                        txd <= par_en ? par_q : 1'b1;
                        stop_q <= two_stop;
                    end else begin
                        bit_q <= bit_q + 3'h1;
                        txd <= sh_q[bit_q + 3'h1];
                    end
                end
                S_PAR: if (bit_end) begin
                    st_q <= S_STOP;
                    txd <= 1'b1;
                end
                S_STOP: if (bit_end) begin
                    if (stop_q)
                        stop_q <= 1'b0;
                    else
                        st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule // tx_shifter

//--- logic/serial_channel.v
// asynchronous serial channel: register file, baud timing, receiver, tx path
`timescale 1ns/1ns
`include "serial_channel_map.vh"
module serial_channel (
    input wire MCLK,
    input wire RESETN,
    input wire CE,
    input wire [15:0] IO_ADDR,
    input wire IO_RD,
    input wire IO_WR,
    input wire [7:0] IO_WDATA,
    output reg [7:0] IO_RDATA,
    input wire [7:0] IO_PAGE_HIGH,
    input wire [7:0] SERIAL_WINDOW_LOW,
    input wire BAUD_SEL,
    input wire TIMER1_OUT,
    input wire RXD,
    input wire DSR_N,
    output reg TXD,
    output reg RTS_N,
    output reg DTR_N,
    output reg IRQ
);
    localparam R_IDLE = 5'b00001;
    localparam R_START = 5'b00010;
    localparam R_DATA = 5'b00100;
    localparam R_PAR = 5'b01000;
    localparam R_STOP = 5'b10000;

    // registers
    reg [7:0] baud_divisor_count_q;
    reg [7:0] line_format_q;
    reg [7:0] line_command_q;
    reg [7:0] irq_mask_q;
    reg [7:0] rx_buffer_q;
    reg rx_full_flag_q;
    reg parity_error_flag_q;
    reg rx_lost_char_flag_q;
    reg framing_error_flag_q;
    reg break_seen_flag_q;

    // pin synchronisers; rx_s3 only feeds the edge detector
    reg rx_s1_q;
    reg rx_s2_q;
    reg rx_s3_q;
    reg dsr_s1_q;
    reg dsr_s2_q;

    // baud source
    reg [7:0] brg_cnt_q;
    reg tmr_prev_q;
    reg os_tick;

    // receiver
    reg [4:0] rst_q;
    reg [5:0] rcnt_q;
    reg [2:0] rbit_q;
    reg [7:0] rsh_q;
    reg rpar_q;

    // bus decode
    // only address bits 7:3 of the window low byte are compared
    wire in_window = (IO_ADDR[15:8] == IO_PAGE_HIGH) &&
                     (IO_ADDR[7:3] == SERIAL_WINDOW_LOW[7:3]);
    wire [1:0] sel = IO_ADDR[2:1];
    wire brc_hit = (IO_ADDR == `BAUD_COUNT_ADDR);
    wire wr_data = IO_WR && in_window && (sel == `SEL_DATA);
    wire wr_cmd = IO_WR && in_window && (sel == `SEL_STATUS);
    wire wr_fmt = IO_WR && in_window && (sel == `SEL_FORMAT);
    wire wr_mask = IO_WR && in_window && (sel == `SEL_MASK);
    wire rd_data = IO_RD && in_window && (sel == `SEL_DATA);

    // format fields, live from the register so a rewrite acts at once
    // illegal codes fall back on the low bit of each field, except the stop field, which uses its high bit
    wire two_stop = line_format_q[`FMT_STOP_HI];
    wire par_en = line_format_q[`FMT_PAR_LO];
    wire par_even = line_format_q[`FMT_PAR_HI];
    wire char8 = line_format_q[`FMT_LEN_LO];
    wire factor_64 = line_format_q[`FMT_BF_LO];
    wire tx_en = line_command_q[`CMD_TX_EN];
    wire rx_en = line_command_q[`CMD_RX_EN];
    wire err_clr = wr_cmd && IO_WDATA[`CMD_ERR_CLR];

    // transmit path
    wire buf_ready;
    wire buf_valid;
    wire [7:0] buf_data;
    wire sh_ready;
    wire sh_txd;
    // empty means room in the holding buffer, not an idle line
    wire tx_empty_flag = buf_ready;

    tx_hold_buffer u_buf (
        .clk(MCLK),
        .rst_n(RESETN),
        .en(CE),
        .in_valid(wr_data),
        .in_data(IO_WDATA),
        .in_ready(buf_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(sh_ready)
    );

    tx_shifter u_shift (
        .clk(MCLK),
        .rst_n(RESETN),
        .en(CE),
        .os_tick(os_tick),
        .factor_64(factor_64),
        .char8(char8),
        .par_en(par_en),
        .par_even(par_even),
        .two_stop(two_stop),
        .tx_enable(tx_en),
        .valid(buf_valid),
        .data(buf_data),
        .ready(sh_ready),
        .txd(sh_txd)
    );

    // receive timing helpers
    wire [5:0] rlast = factor_64 ? `FACTOR_64_LAST : `FACTOR_16_LAST;
    wire [5:0] rhalf = factor_64 ? `HALF_64_LAST : `HALF_16_LAST;
    wire [2:0] rlast_bit = char8 ? 3'h7 : 3'h6;
    wire rbit_end = os_tick && (rcnt_q == rlast);
    wire rmid = os_tick && (rcnt_q == rhalf);
    wire fall = rx_s3_q && !rx_s2_q;
    wire rx_done = rst_q[4] && rbit_end;
    wire par_exp = par_even ? ^rsh_q : ~^rsh_q;

    // set-ready reads as one while its pin is low
    wire [7:0] status = {!dsr_s2_q, break_seen_flag_q, framing_error_flag_q,
                         rx_lost_char_flag_q, parity_error_flag_q, 1'b1,
                         rx_full_flag_q, tx_empty_flag};

    // baud source tick: internal divider or rising edge of timer 1
    always @* begin
        if (BAUD_SEL)
            os_tick = TIMER1_OUT && !tmr_prev_q;
        else
            os_tick = (brg_cnt_q == 8'h00);
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            brg_cnt_q <= 8'h00;
            tmr_prev_q <= 1'b0;
        end else if (CE) begin
            tmr_prev_q <= TIMER1_OUT;
            // a new divisor count waits for the next reload, so a rewrite
            // mid-period still finishes the old period first
            if (brg_cnt_q == 8'h00)
                brg_cnt_q <= baud_divisor_count_q;
            else
                brg_cnt_q <= brg_cnt_q - 8'h01;
        end
    end

    // pin synchronisers
    always @(posedge MCLK) begin
        if (!RESETN) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            dsr_s1_q <= 1'b1;
            dsr_s2_q <= 1'b1;
        end else if (CE) begin
            rx_s1_q <= RXD;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            dsr_s1_q <= DSR_N;
            dsr_s2_q <= dsr_s1_q;
        end
    end

    // software registers
    always @(posedge MCLK) begin
        if (!RESETN) begin
            baud_divisor_count_q <= `BAUD_COUNT_RESET;
            line_format_q <= `FORMAT_RESET;
            line_command_q <= `COMMAND_RESET;
            irq_mask_q <= `MASK_RESET;
        end else if (CE) begin
            if (IO_WR && brc_hit)
                baud_divisor_count_q <= IO_WDATA;
            if (wr_fmt)
                line_format_q <= IO_WDATA;
            // error clear is a strobe and is never stored
            if (wr_cmd)
                line_command_q <= IO_WDATA & ~(8'h01 << `CMD_ERR_CLR);
            if (wr_mask)
                irq_mask_q <= {6'h00, IO_WDATA[1:0]};
        end
    end

    // bus read data, one cycle after the strobe
    always @(posedge MCLK) begin
        if (!RESETN) begin
            IO_RDATA <= 8'h00;
        end else if (CE) begin
            IO_RDATA <= 8'h00;
            // format slot and misses read back as zero
            if (IO_RD && brc_hit)
                IO_RDATA <= baud_divisor_count_q;
            else if (IO_RD && in_window) begin
                case (sel)
                    `SEL_DATA: IO_RDATA <= rx_buffer_q;
                    `SEL_STATUS: IO_RDATA <= status;
                    `SEL_MASK: IO_RDATA <= irq_mask_q;
                    default: IO_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // receiver state machine
    always @(posedge MCLK) begin
        if (!RESETN) begin
            rst_q <= R_IDLE;
            rcnt_q <= 6'h00;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rpar_q <= 1'b0;
        end else if (CE) begin
            if (os_tick)
                rcnt_q <= rbit_end ? 6'h00 : rcnt_q + 6'h01;
            case (rst_q)
                R_IDLE: begin
                    if (rx_en && fall) begin
                        rst_q <= R_START;
                        rcnt_q <= 6'h00;
                        rsh_q <= 8'h00;
                        rpar_q <= 1'b0;
                    end
                end
                R_START: begin
                    // realign the counter on the centre of the start bit
                    // a start bit gone high by its centre is taken as noise
                    if (rmid) begin
                        rcnt_q <= 6'h00;
                        rbit_q <= 3'h0;
                        rst_q <= rx_s2_q ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (rbit_end) begin
                        rsh_q[rbit_q] <= rx_s2_q;
                        if (rbit_q == rlast_bit)
                            rst_q <= par_en ? R_PAR : R_STOP;
                        else
                            rbit_q <= rbit_q + 3'h1;
                    end
                end
                R_PAR: begin
                    if (rbit_end) begin
                        rpar_q <= rx_s2_q;
                        rst_q <= R_STOP;
                    end
                end
                R_STOP: begin
                    // only the first stop bit is checked
                    if (rbit_end)
                        rst_q <= R_IDLE;
                end
                default: rst_q <= R_IDLE;
            endcase
            // disabling the receiver drops a half-built character
            if (!rx_en && !rst_q[0])
                rst_q <= R_IDLE;
        end
    end

    // receive buffer and sticky flags; a setting event beats a clear
    always @(posedge MCLK) begin
        if (!RESETN) begin
            rx_buffer_q <= 8'h00;
            rx_full_flag_q <= 1'b0;
            parity_error_flag_q <= 1'b0;
            rx_lost_char_flag_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            break_seen_flag_q <= 1'b0;
        end else if (CE) begin
            if (rd_data)
                rx_full_flag_q <= 1'b0;
            if (err_clr) begin
                parity_error_flag_q <= 1'b0;
                rx_lost_char_flag_q <= 1'b0;
                framing_error_flag_q <= 1'b0;
            end
            if (rx_s2_q)
                break_seen_flag_q <= 1'b0;
            if (rx_done) begin
                rx_buffer_q <= rsh_q;
                rx_full_flag_q <= 1'b1;
                // a read in the same cycle makes room, so no overrun
                if (rx_full_flag_q && !rd_data)
                    rx_lost_char_flag_q <= 1'b1;
                if (!rx_s2_q)
                    framing_error_flag_q <= 1'b1;
                if (par_en && (rpar_q != par_exp))
                    parity_error_flag_q <= 1'b1;
                if (rsh_q == 8'h00 && !rpar_q && !rx_s2_q)
                    break_seen_flag_q <= 1'b1;
            end
        end
    end

    // pins and request, all registered
    always @(posedge MCLK) begin
        if (!RESETN) begin
            TXD <= 1'b1;
            RTS_N <= 1'b1;
            DTR_N <= 1'b1;
            IRQ <= 1'b0;
        end else if (CE) begin
            // break forces the line low even mid-character
            TXD <= sh_txd && !line_command_q[`CMD_BREAK];
            RTS_N <= !line_command_q[`CMD_RTS];
            DTR_N <= !line_command_q[`CMD_DTR];
            // registered, so the request trails its flags by one cycle
            IRQ <= (rx_en && rx_full_flag_q && !irq_mask_q[`MASK_RX]) ||
                   (tx_en && tx_empty_flag && !irq_mask_q[`MASK_TX]);
        end
    end
endmodule // serial_channel

//--- test/serial_channel_monitor.sv
// assertion checker on the serial channel top-level ports
`timescale 1ns/1ns
`include "serial_channel_map.vh"
module serial_channel_monitor (
    input wire MCLK,
    input wire RESETN,
    input wire CE,
    input wire [15:0] IO_ADDR,
    input wire IO_RD,
    input wire IO_WR,
    input wire [7:0] IO_WDATA,
    input wire [7:0] IO_RDATA,
    input wire [7:0] IO_PAGE_HIGH,
    input wire [7:0] SERIAL_WINDOW_LOW,
    input wire TXD,
    input wire RTS_N,
    input wire DTR_N,
    input wire IRQ
);
    wire hit = IO_ADDR[15:8] == IO_PAGE_HIGH && IO_ADDR[7:3] == SERIAL_WINDOW_LOW[7:3];
    wire rd = CE && IO_RD && hit;
    wire wr = CE && IO_WR && hit;
    reg [1:0] mask_q;
    reg [3:0] cmd_q;
    // shadow copies, so the quiet and break checks know what was programmed
    always @(posedge MCLK) begin
        if (!RESETN) begin
            mask_q <= 2'h3;
            cmd_q <= 4'h0;
        end else if (wr && IO_ADDR[2:1] == `SEL_MASK) begin
            mask_q <= IO_WDATA[1:0];
        end else if (wr && IO_ADDR[2:1] == `SEL_STATUS) begin
            cmd_q <= IO_WDATA[3:0];
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    reset_state_a: assert property ($rose(RESETN) |-> TXD && RTS_N && DTR_N && !IRQ && IO_RDATA == 8'h00)
        else $error("outputs not at reset state");
    rdata_idle_a: assert property (CE && !IO_RD |=> IO_RDATA == 8'h00)
        else $error("read data not zero without a read");
    status_one_a: assert property (rd && IO_ADDR[2:1] == `SEL_STATUS |=> IO_RDATA[2])
        else $error("status bit 2 not one");
    format_blind_a: assert property (rd && IO_ADDR[2:1] == `SEL_FORMAT |=> IO_RDATA == 8'h00)
        else $error("format read not zero");
    mask_read_a: assert property (rd && IO_ADDR[2:1] == `SEL_MASK |=> IO_RDATA == {6'h00, $past(mask_q)})
        else $error("mask read back wrong");
    modem_out_a: assert property (wr && IO_ADDR[2:1] == `SEL_STATUS |=> ##1
        RTS_N == !$past(IO_WDATA[5], 2) && DTR_N == !$past(IO_WDATA[1], 2))
        else $error("modem outputs do not follow command");
    mask_quiet_a: assert property (mask_q == 2'h3 && $past(mask_q) == 2'h3 && $past(mask_q, 2) == 2'h3 |-> !IRQ)
        else $error("request while both masked");
    enable_quiet_a: assert property (cmd_q[0] == 1'b0 && cmd_q[2] == 1'b0 && $past(cmd_q[0]) == 1'b0
        && $past(cmd_q[2]) == 1'b0 && $past(cmd_q[0], 2) == 1'b0 && $past(cmd_q[2], 2) == 1'b0 |-> !IRQ)
        else $error("request while both directions disabled");
    tx_gate_a: assert property ($fell(TXD) |-> cmd_q[0] || cmd_q[3])
        else $error("line fell while transmitter disabled");
    break_low_a: assert property (cmd_q[3] && $past(cmd_q[3]) && $past(cmd_q[3], 2) |-> !TXD)
        else $error("line not held low during break");
endmodule // serial_channel_monitor
bind serial_channel serial_channel_monitor u_serial_channel_monitor (.MCLK(MCLK), .RESETN(RESETN), .CE(CE),
    .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_WR(IO_WR), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .IO_PAGE_HIGH(IO_PAGE_HIGH), .SERIAL_WINDOW_LOW(SERIAL_WINDOW_LOW), .TXD(TXD), .RTS_N(RTS_N),
    .DTR_N(DTR_N), .IRQ(IRQ));

//--- test/serial_peer.sv
// far-side serial device model: frames characters onto RXD, captures TXD
`timescale 1ns/1ns
module serial_peer (
    input wire clk,
    input wire line_in,
    output reg line_out
);
    integer bit_len;
    time t_start;
    initial begin
        bit_len = 16;
        t_start = 0;
        line_out = 1'b1;
    end
    // err[0] inverts parity; err[1] sends a low stop and leaves the line low
    task send(input [7:0] d, input integer nb, input [1:0] par, input [1:0] err);
        reg [7:0] m;
        integer i;
        begin
            m = (nb == 8) ? d : {1'b0, d[6:0]};
            @(negedge clk);
            line_out = 1'b0;
            repeat (bit_len) @(negedge clk);
            for (i = 0; i < nb; i = i + 1) begin
                line_out = m[i];
                repeat (bit_len) @(negedge clk);
            end
            if (par[0]) begin
                line_out = ^m ^ ~par[1] ^ err[0];
                repeat (bit_len) @(negedge clk);
            end
            line_out = ~err[1];
            repeat (bit_len) @(negedge clk);
        end
    endtask
    task mark;
        begin
            @(negedge clk);
            line_out = 1'b1;
        end
    endtask
    // gives {stop, parity, data}; only the first stop is looked at
    task recv(output [9:0] w, input integer nb, input pe);
        integer i;
        begin
            w = 10'h000;
            @(negedge line_in);
            t_start = $time;
            // sample on the falling edge, away from the edge that moves the line
            repeat (bit_len / 2) @(negedge clk);
            for (i = 0; i < nb; i = i + 1) begin
                repeat (bit_len) @(negedge clk);
                w[i] = line_in;
            end
            if (pe) begin
                repeat (bit_len) @(negedge clk);
                w[8] = line_in;
            end
            repeat (bit_len) @(negedge clk);
            w[9] = line_in;
        end
    endtask
endmodule // serial_peer

//--- test/async_serial_channel_test.sv
// register-level bench for the serial channel with a line-side peer
`timescale 1ns/1ns
module async_serial_channel_test;
    localparam [15:0] at_data = 16'h1240;
    localparam [15:0] at_stat = 16'h1242;
    localparam [15:0] at_fmt = 16'h1244;
    localparam [15:0] at_mask = 16'h1246;
    reg MCLK = 1'b0;
    reg RESETN = 1'b0;
    reg [15:0] IO_ADDR = 16'h0000;
    reg IO_RD = 1'b0;
    reg IO_WR = 1'b0;
    reg [7:0] IO_WDATA = 8'h00;
    reg DSR_N = 1'b1;
    reg BAUD_SEL = 1'b0;
    reg TIMER1_OUT = 1'b0;
    wire [7:0] IO_RDATA;
    wire RXD, TXD, RTS_N, DTR_N, IRQ;
    integer fails = 0;
    integer checks = 0;
    integer i, nb;
    reg [1:0] par;
    reg [7:0] r, e;
    reg [9:0] w, v;
    time t0;
    `define CMP(a, x) begin checks = checks + 1; if ((a) !== (x)) begin fails = fails + 1; \
        $display("BAD t=%0t got=%h exp=%h", $time, a, x); end end
    serial_channel u_serial_channel (.MCLK(MCLK), .RESETN(RESETN), .CE(1'b1), .IO_ADDR(IO_ADDR), .IO_RD(IO_RD),
        .IO_WR(IO_WR), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_PAGE_HIGH(8'h12), .SERIAL_WINDOW_LOW(8'h40),
        .BAUD_SEL(BAUD_SEL), .TIMER1_OUT(TIMER1_OUT), .RXD(RXD), .DSR_N(DSR_N), .TXD(TXD), .RTS_N(RTS_N),
        .DTR_N(DTR_N),
        .IRQ(IRQ));
    serial_peer u_serial_peer (.clk(MCLK), .line_in(TXD), .line_out(RXD));
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    // timer 1 stand-in: one rising edge every second cycle
    always @(negedge MCLK) TIMER1_OUT <= ~TIMER1_OUT;
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge MCLK);
            IO_ADDR = a;
            IO_WDATA = d;
            IO_WR = 1'b1;
            @(negedge MCLK);
            IO_WR = 1'b0;
        end
    endtask
    task rd(input [15:0] a, output [7:0] d);
        begin
            @(negedge MCLK);
            IO_ADDR = a;
            IO_RD = 1'b1;
            @(negedge MCLK);
            IO_RD = 1'b0;
            d = IO_RDATA;
        end
    endtask
    task poll(input integer b);
        integer n;
        begin
            n = 0;
            r = 8'h00;
            while (r[b] !== 1'b1 && n < 400) begin
                rd(at_stat, r);
                n = n + 1;
            end
            `CMP(r[b], 1'b1)
        end
    endtask
    task txchk(input [7:0] d, input integer nb, input [1:0] par);
        begin
            e = (nb == 8) ? d : {1'b0, d[6:0]};
            fork
                u_serial_peer.recv(w, nb, par[0]);
                wr(at_data, d);
            join
            `CMP(w, {1'b1, par[0] & (^e ^ ~par[1]), e})
        end
    endtask
    task rxchk(input [7:0] d, input integer nb, input [1:0] par);
        begin
            u_serial_peer.send(d, nb, par, 2'b00);
            poll(1);
            rd(at_data, r);
            e = (nb == 8) ? d : {1'b0, d[6:0]};
            `CMP(r, e)
        end
    endtask
    task close_out;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge MCLK);
        fails = fails + 1;
        close_out;
    end
    initial begin
        repeat (10) @(negedge MCLK);
        RESETN = 1'b1;
        rd(at_stat, r);
        `CMP(r, 8'h05)
        `CMP({TXD, RTS_N, DTR_N, IRQ}, 4'hE)
        rd(at_mask, r);
        `CMP(r, 8'h03)
        rd(at_fmt, r);
        `CMP(r, 8'h00)
        wr(16'hFFE9, 8'h5A);
        rd(16'hFFE9, r);
        `CMP(r, 8'h5A)
        rd(16'hFFE8, r);
        `CMP(r, 8'h00)
        wr(16'hFFE9, 8'h00);
        // let the long count from the test value run out first
        repeat (100) @(negedge MCLK);
        // reset format: factor 64, seven bits, one stop
        u_serial_peer.bit_len = 64;
        wr(at_stat, 8'h27);
        repeat (3) @(negedge MCLK);
        `CMP({RTS_N, DTR_N}, 2'b00)
        txchk(8'hFF, 7, 2'b00);
        rxchk(8'hFF, 7, 2'b00);
        u_serial_peer.bit_len = 16;
        for (i = 0; i < 6; i = i + 1) begin
            par = (i % 3 == 0) ? 2'b00 : (i % 3 == 1) ? 2'b01 : 2'b11;
            nb = (i < 3) ? 8 : 7;
            wr(at_fmt, {2'b01, par, 1'b1, nb == 8, 2'b10});
            txchk(8'hA5 ^ {5'h00, i[2:0]}, nb, par);
            rxchk(8'hC3 ^ {5'h00, i[2:0]}, nb, par);
        end
        wr(at_fmt, 8'h7E);
        u_serial_peer.send(8'h3C, 8, 2'b11, 2'b01);
        poll(1);
        rd(at_data, r);
        rd(at_stat, r);
        `CMP(r[5:3], 3'b001)
        u_serial_peer.send(8'h3C, 8, 2'b11, 2'b10);
        poll(1);
        u_serial_peer.mark;
        rd(at_data, r);
        rd(at_stat, r);
        `CMP(r[5:3], 3'b101)
        u_serial_peer.send(8'h11, 8, 2'b11, 2'b00);
        u_serial_peer.send(8'h22, 8, 2'b11, 2'b00);
        poll(4);
        rd(at_data, r);
        wr(at_stat, 8'h37);
        rd(at_stat, r);
        `CMP(r[5:3], 3'b000)
        u_serial_peer.send(8'h00, 8, 2'b11, 2'b10);
        poll(6);
        u_serial_peer.mark;
        repeat (8) @(negedge MCLK);
        rd(at_stat, r);
        `CMP(r[6], 1'b0)
        rd(at_data, r);
        wr(at_stat, 8'h37);
        // request line: transmit side, then receive side
        wr(at_mask, 8'h01);
        repeat (3) @(negedge MCLK);
        `CMP(IRQ, 1'b1)
        wr(at_mask, 8'h02);
        rd(at_mask, r);
        `CMP({r, IRQ}, 9'h004)
        u_serial_peer.send(8'h5A, 8, 2'b11, 2'b00);
        poll(1);
        repeat (3) @(negedge MCLK);
        `CMP(IRQ, 1'b1)
        rd(at_data, r);
        repeat (3) @(negedge MCLK);
        `CMP(IRQ, 1'b0)
        wr(at_mask, 8'h03);
        // fill the holding buffer with the transmitter off, then drain it
        wr(at_stat, 8'h26);
        wr(at_fmt, 8'hCE);
        wr(at_data, 8'h81);
        rd(at_stat, r);
        `CMP(r[0], 1'b1)
        wr(at_data, 8'h42);
        rd(at_stat, r);
        `CMP({r[0], TXD}, 2'b01)
        wr(at_data, 8'hFF);
        fork
            begin
                u_serial_peer.recv(w, 8, 1'b0);
                t0 = u_serial_peer.t_start;
                u_serial_peer.recv(v, 8, 1'b0);
            end
            wr(at_stat, 8'h27);
        join
        `CMP({w, v}, {10'h281, 10'h242})
        `CMP((u_serial_peer.t_start - t0) / 10 >= 176, 1'b1)
        rd(at_stat, r);
        `CMP({r[0], TXD}, 2'b11)
        wr(at_stat, 8'h2F);
        repeat (4) @(negedge MCLK);
        `CMP(TXD, 1'b0)
        wr(at_stat, 8'h27);
        DSR_N = 1'b0;
        repeat (4) @(negedge MCLK);
        rd(at_stat, r);
        `CMP({r[7], TXD}, 2'b11)
        // baud ticks from timer 1, so each bit takes 32 cycles at x16
        BAUD_SEL = 1'b1;
        u_serial_peer.bit_len = 32;
        txchk(8'h96, 8, 2'b00);
        rxchk(8'h69, 8, 2'b00);
        close_out;
    end
endmodule // async_serial_channel_test
